/* File: cbi_irq_ctrl.sv */
// interrupt enables, sticky status and axi4-lite slave of the converter board
//
// What this block does
// - manual mode: enabled output channel flags irq when its settling flag falls
// - enable bit 12 flags irq when input conversion count is reached
// - enable bit 8 flags irq when input buffer is terminated by dma
// - input buffer termination cause is stored beside its status flag
// - enable bit 4 flags irq when output conversion count is reached
// - enable bit 0 flags irq when output buffer is terminated by dma
// - error bit 27 flags input frame trigger before count completes
// - error bit 26 flags new input conversion request while converters busy
// - error bit 25 flags input sample write into a full queue
// - error bit 24 flags input dma host bus abort
// - error bit 19 flags output frame trigger before count completes
// - error bit 18 flags output conversion request while a converter busy
// - error bit 17 flags output underrun from missing preload
// - error bit 16 flags output dma host bus abort
// - error bits 0 to 3 flag channel alert on status read with fault
// - enables are read/write, reset zero, one enables, reserved bits inert
// - a status flag sets only if its enable was already set
// - clearing an enable clears its status flag
// - interrupt line is high while any status bit is set
// - event status bits clear when the status register is read
`default_nettype none
module cbi_irq_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  // axi4-lite write response
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  // conversion events
  input wire logic i_manual_mode,
  input wire logic [3:0] i_out_settling,
  input wire logic i_input_count_done,
  input wire logic i_input_buffer_end,
  input wire logic [1:0] i_input_buffer_cause,
  input wire logic i_output_count_done,
  input wire logic i_output_buffer_end,
  // error events
  input wire logic i_input_frame_fault,
  input wire logic i_input_overrun,
  input wire logic i_sample_queue_full,
  input wire logic i_input_bus_abort,
  input wire logic i_output_frame_fault,
  input wire logic i_output_busy_fault,
  input wire logic i_output_underrun,
  input wire logic i_output_bus_abort,
  input wire logic [3:0] i_out_alert_read,
  input wire logic [3:0] i_out_alert_cond,
  // host interrupt
  output logic o_irq
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic cbi_pkg::cbi_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
    logic [11:0] ofs;
    ofs = 12'(addr);
    unique case (ofs)
      cbi_pkg::IRQ_ENABLE_OFS: reg_sel = cbi_pkg::CBI_SEL_IRQ_EN;
      cbi_pkg::ERROR_IRQ_ENABLE_OFS: reg_sel = cbi_pkg::CBI_SEL_ERR_EN;
      cbi_pkg::ERROR_IRQ_STATUS_OFS: reg_sel = cbi_pkg::CBI_SEL_ERR_STAT;
      cbi_pkg::IRQ_STATUS_OFS: reg_sel = cbi_pkg::CBI_SEL_IRQ_STAT;
      default: reg_sel = cbi_pkg::CBI_SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  logic [ADDR_W-1:0] awaddr_q;
  logic aw_full_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] irq_en_q;
  logic [31:0] err_en_q;
  logic [3:0] settling_prev_q;
  logic [1:0] cause_q;
  logic [31:0] irq_ev;
  logic [31:0] err_ev;
  logic [31:0] irq_flags;
  logic [31:0] err_flags;
  logic [31:0] irq_stat_rd;
  logic [31:0] wmask;
  logic err_any;
  logic do_wr;
  logic ar_hs;
  logic rd_irq_clr;
  logic rd_err_clr;
  cbi_pkg::cbi_sel_e wr_sel;
  cbi_pkg::cbi_sel_e rd_sel;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // one write at a time: address and data are parked until both are in
  assign o_axi_awready = !aw_full_q && !bvalid_q;
  assign o_axi_wready = !w_full_q && !bvalid_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel = reg_sel(awaddr_q);
  assign wmask = byte_mask(wstrb_q);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (i_axi_awvalid && o_axi_awready)
    begin
      aw_full_q <= 1'b1;
      awaddr_q <= i_axi_awaddr;
    end
    else if (do_wr)
    begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (i_axi_wvalid && o_axi_wready)
    begin
      w_full_q <= 1'b1;
      wdata_q <= i_axi_wdata;
      wstrb_q <= i_axi_wstrb;
    end
    else if (do_wr)
    begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= cbi_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == cbi_pkg::CBI_SEL_NONE) ? cbi_pkg::RESP_SLVERR : cbi_pkg::RESP_OKAY;
    end
    else if (i_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign o_axi_bvalid = bvalid_q;
  assign o_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  // status registers ignore writes; only the enables can be changed
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      irq_en_q <= cbi_pkg::ENABLE_RESET;
      err_en_q <= cbi_pkg::ENABLE_RESET;
    end
    else if (do_wr)
    begin
      if (wr_sel == cbi_pkg::CBI_SEL_IRQ_EN)
      begin
        irq_en_q <= ((irq_en_q & ~wmask) | (wdata_q & wmask)) & cbi_pkg::IRQ_EN_MASK;
      end
      if (wr_sel == cbi_pkg::CBI_SEL_ERR_EN)
      begin
        err_en_q <= ((err_en_q & ~wmask) | (wdata_q & wmask)) & cbi_pkg::ERR_EN_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // event gathering
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      settling_prev_q <= '0;
    end
    else
    begin
      settling_prev_q <= i_out_settling;
    end
  end

  always_comb
  begin
    irq_ev = '0;
    irq_ev[cbi_pkg::OUT_SETTLED_LSB +: 4] =
      settling_prev_q & ~i_out_settling & {4{i_manual_mode}};
    irq_ev[cbi_pkg::INPUT_COUNT_DONE_BIT] = i_input_count_done;
    irq_ev[cbi_pkg::INPUT_BUFFER_END_BIT] = i_input_buffer_end;
    irq_ev[cbi_pkg::OUTPUT_COUNT_DONE_BIT] = i_output_count_done;
    irq_ev[cbi_pkg::OUTPUT_BUFFER_END_BIT] = i_output_buffer_end;
    err_ev = '0;
    err_ev[cbi_pkg::INPUT_FRAME_FAULT_BIT] = i_input_frame_fault;
    err_ev[cbi_pkg::INPUT_OVERRUN_BIT] = i_input_overrun;
    err_ev[cbi_pkg::SAMPLE_QUEUE_FULL_BIT] = i_sample_queue_full;
    err_ev[cbi_pkg::INPUT_BUS_ABORT_BIT] = i_input_bus_abort;
    err_ev[cbi_pkg::OUTPUT_FRAME_FAULT_BIT] = i_output_frame_fault;
    err_ev[cbi_pkg::OUTPUT_BUSY_FAULT_BIT] = i_output_busy_fault;
    err_ev[cbi_pkg::OUTPUT_UNDERRUN_BIT] = i_output_underrun;
    err_ev[cbi_pkg::OUTPUT_BUS_ABORT_BIT] = i_output_bus_abort;
    err_ev[cbi_pkg::OUT_ALERT_LSB +: 4] = i_out_alert_read & i_out_alert_cond;
  end

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_flag
      if (cbi_pkg::IRQ_EN_MASK[gi])
      begin : g_irq
        cbi_sticky_bit u_irq (
          .i_clk(i_clk),
          .i_nrst(i_nrst),
          .i_en(irq_en_q[gi]),
          .i_event(irq_ev[gi]),
          .i_rd_clr(rd_irq_clr),
          .o_flag(irq_flags[gi])
        );
      end
      else
      begin : g_irq_none
        assign irq_flags[gi] = 1'b0;
      end
      if (cbi_pkg::ERR_EN_MASK[gi])
      begin : g_err
        cbi_sticky_bit u_err (
          .i_clk(i_clk),
          .i_nrst(i_nrst),
          .i_en(err_en_q[gi]),
          .i_event(err_ev[gi]),
          .i_rd_clr(rd_err_clr),
          .o_flag(err_flags[gi])
        );
      end
      else
      begin : g_err_none
        assign err_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // cause follows the flag: it is taken only when the flag is allowed to set
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cause_q <= '0;
    end
    else if (irq_en_q[cbi_pkg::INPUT_BUFFER_END_BIT] && i_input_buffer_end)
    begin
      cause_q <= i_input_buffer_cause;
    end
    else if (rd_irq_clr || !irq_en_q[cbi_pkg::INPUT_BUFFER_END_BIT])
    begin
      cause_q <= '0;
    end
  end

  assign err_any = |err_flags;
  assign o_irq = (|irq_flags) || err_any;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign o_axi_arready = !rvalid_q;
  assign ar_hs = i_axi_arvalid && o_axi_arready;
  assign rd_sel = reg_sel(i_axi_araddr);
  assign rd_irq_clr = ar_hs && (rd_sel == cbi_pkg::CBI_SEL_IRQ_STAT);
  assign rd_err_clr = ar_hs && (rd_sel == cbi_pkg::CBI_SEL_ERR_STAT);

  always_comb
  begin
    irq_stat_rd = irq_flags;
    irq_stat_rd[cbi_pkg::BUFFER_END_CAUSE_LSB +: 2] = cause_q;
    irq_stat_rd[cbi_pkg::ERROR_SUMMARY_BIT] = err_any;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= cbi_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= cbi_pkg::RESP_OKAY;
      unique case (rd_sel)
        cbi_pkg::CBI_SEL_IRQ_EN: rdata_q <= irq_en_q;
        cbi_pkg::CBI_SEL_ERR_EN: rdata_q <= err_en_q;
        cbi_pkg::CBI_SEL_ERR_STAT: rdata_q <= err_flags;
        cbi_pkg::CBI_SEL_IRQ_STAT: rdata_q <= irq_stat_rd;
        cbi_pkg::CBI_SEL_NONE:
        begin
          rdata_q <= '0;
          rresp_q <= cbi_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (i_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_axi_rvalid = rvalid_q;
  assign o_axi_rdata = rdata_q;
  assign o_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  AST_SETTLE_FALL: assert property (
    irq_en_q[16] && i_manual_mode && settling_prev_q[0] && !i_out_settling[0] |=> irq_flags[16])
    else $error("settle-done flag not set after settling fell");
  AST_IN_COUNT: assert property (
    irq_en_q[12] && i_input_count_done |=> irq_flags[12] ##0 o_irq)
    else $error("input count done flag or irq missing");
  AST_IN_BUF_END: assert property (
    irq_en_q[8] && i_input_buffer_end |=> irq_flags[8])
    else $error("input buffer end flag missing");
  AST_CAUSE: assert property (
    irq_en_q[8] && i_input_buffer_end |=> cause_q == $past(i_input_buffer_cause))
    else $error("buffer end cause not stored");
  AST_OUT_COUNT: assert property (
    irq_en_q[4] && i_output_count_done |=> irq_flags[4])
    else $error("output count done flag missing");
  AST_OUT_BUF_END: assert property (
    irq_en_q[0] && i_output_buffer_end |=> irq_flags[0])
    else $error("output buffer end flag missing");
  AST_IN_FRAME: assert property (
    err_en_q[27] && i_input_frame_fault |=> err_flags[27] && irq_stat_rd[30])
    else $error("input frame fault flag missing");
  AST_IN_OVERRUN: assert property (
    err_en_q[26] && i_input_overrun |=> err_flags[26])
    else $error("input overrun flag missing");
  AST_QUEUE_FULL: assert property (
    err_en_q[25] && i_sample_queue_full |=> err_flags[25])
    else $error("sample queue full flag missing");
  AST_IN_ABORT: assert property (
    err_en_q[24] && i_input_bus_abort |=> err_flags[24])
    else $error("input bus abort flag missing");
  AST_OUT_FRAME: assert property (
    err_en_q[19] && i_output_frame_fault |=> err_flags[19])
    else $error("output frame fault flag missing");
  AST_OUT_BUSY: assert property (
    err_en_q[18] && i_output_busy_fault |=> err_flags[18])
    else $error("output busy fault flag missing");
  AST_UNDERRUN: assert property (
    err_en_q[17] && i_output_underrun |=> err_flags[17])
    else $error("output underrun flag missing");
  AST_OUT_ABORT: assert property (
    err_en_q[16] && i_output_bus_abort |=> err_flags[16])
    else $error("output bus abort flag missing");
  AST_ALERT: assert property (
    err_en_q[3] && i_out_alert_read[3] && i_out_alert_cond[3] |=> err_flags[3])
    else $error("channel alert flag missing");
  AST_RESERVED: assert property (
    ((irq_en_q & ~cbi_pkg::IRQ_EN_MASK) == '0) && ((err_en_q & ~cbi_pkg::ERR_EN_MASK) == '0))
    else $error("reserved enable bit set");
  AST_NEED_ENABLE: assert property (
    $rose(irq_flags[12]) |-> $past(irq_en_q[12]) && $past(i_input_count_done))
    else $error("flag set without prior enable");
  AST_DISABLE_CLEARS: assert property (
    !err_en_q[24] |=> !err_flags[24])
    else $error("disabled enable left its flag set");
  AST_IRQ_LINE: assert property (
    o_irq == ((|irq_flags) || (|err_flags)))
    else $error("irq line disagrees with status");
  AST_READ_CLEAR: assert property (
    rd_irq_clr && !irq_ev[12] |=> !irq_flags[12] && o_axi_rvalid)
    else $error("status read did not clear flag");
  AST_SUMMARY: assert property (
    $rose(err_any) |-> o_irq && irq_stat_rd[cbi_pkg::ERROR_SUMMARY_BIT])
    else $error("error summary not driving irq");
  AST_WRITE_RESP: assert property (
    do_wr |=> o_axi_bvalid)
    else $error("write response late");

  COV_SETTLE: cover property (irq_en_q[16] && settling_prev_q[0] && !i_out_settling[0]);
  COV_SET_AND_CLEAR: cover property (rd_irq_clr && irq_ev[8] && irq_en_q[8]);
  COV_ERR_IRQ: cover property ($rose(err_any));
  COV_BAD_ADDR: cover property (o_axi_rvalid && o_axi_rresp == cbi_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

/* File: cbi_pkg.sv */
// shared constants for the converter board interrupt enable block
`default_nettype none
package cbi_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h36C;
  localparam logic [11:0] ERROR_IRQ_ENABLE_OFS = 12'h370;
  localparam logic [11:0] ERROR_IRQ_STATUS_OFS = 12'h380;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h384;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OUT_SETTLED_LSB = 16;
  localparam int INPUT_COUNT_DONE_BIT = 12;
  localparam int INPUT_BUFFER_END_BIT = 8;
  localparam int OUTPUT_COUNT_DONE_BIT = 4;
  localparam int OUTPUT_BUFFER_END_BIT = 0;
  localparam int BUFFER_END_CAUSE_LSB = 9;
  localparam int ERROR_SUMMARY_BIT = 30;
  localparam int INPUT_FRAME_FAULT_BIT = 27;
  localparam int INPUT_OVERRUN_BIT = 26;
  localparam int SAMPLE_QUEUE_FULL_BIT = 25;
  localparam int INPUT_BUS_ABORT_BIT = 24;
  localparam int OUTPUT_FRAME_FAULT_BIT = 19;
  localparam int OUTPUT_BUSY_FAULT_BIT = 18;
  localparam int OUTPUT_UNDERRUN_BIT = 17;
  localparam int OUTPUT_BUS_ABORT_BIT = 16;
  localparam int OUT_ALERT_LSB = 0;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] IRQ_EN_MASK = 32'h000F_1111;
  localparam logic [31:0] ERR_EN_MASK = 32'h0F0F_000F;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CBI_SEL_NONE,
    CBI_SEL_IRQ_EN,
    CBI_SEL_ERR_EN,
    CBI_SEL_ERR_STAT,
    CBI_SEL_IRQ_STAT
  } cbi_sel_e;
endpackage
`default_nettype wire

/* File: cbi_sticky_bit.sv */
// one sticky, read-clear interrupt status flag gated by its enable
`default_nettype none
module cbi_sticky_bit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_en,
  input wire logic i_event,
  input wire logic i_rd_clr,
  // flag
  output logic o_flag
);
  logic flag_q;
  logic flag_d;

  always_comb
  begin
    flag_d = flag_q;
    if (!i_en)
    begin
      flag_d = 1'b0;
    end
    else if (i_event)
    begin
      // set beats a read clear in the same cycle so no event is lost
      flag_d = 1'b1;
    end
    else if (i_rd_clr)
    begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the converter board interrupt enable block
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_clk, i_nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mm, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, settle, iev, ard, acond;
  logic [1:0] bresp, rresp, cause;
  logic [7:0] eev;
  int n_mismatch = 0;
  int tests_run = 0;
  cbi_irq_ctrl uut (
    .i_clk(i_clk), .i_nrst(i_nrst),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .i_manual_mode(mm), .i_out_settling(settle),
    .i_input_count_done(iev[3]), .i_input_buffer_end(iev[2]),
    .i_input_buffer_cause(cause), .i_output_count_done(iev[1]),
    .i_output_buffer_end(iev[0]),
    .i_input_frame_fault(eev[7]), .i_input_overrun(eev[6]),
    .i_sample_queue_full(eev[5]), .i_input_bus_abort(eev[4]),
    .i_output_frame_fault(eev[3]), .i_output_busy_fault(eev[2]),
    .i_output_underrun(eev[1]), .i_output_bus_abort(eev[0]),
    .i_out_alert_read(ard), .i_out_alert_cond(acond), .o_irq(irq)
  );
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------
  // bus and event helpers
  // ----------------------------------------------------------------
  // handshakes are judged at the falling edge so the combinational readies are settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    r = 2'h1;
    while (!hb)
    begin
      @(negedge i_clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid & bready;
      if (hb) r = bresp;
      @(posedge i_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // let an edge pass so the next call never re-raises bready in this time step
    @(posedge i_clk);
    `CHK(r, er)
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er = cbi_pkg::RESP_OKAY);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    d = 32'hDEAD_BEEF;
    r = 2'h1;
    while (!hr)
    begin
      @(negedge i_clk);
      ha = arvalid & arready;
      hr = rvalid & rready;
      if (hr) d = rdata;
      if (hr) r = rresp;
      @(posedge i_clk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge i_clk);
    `CHK(d, e)
    `CHK(r, er)
  endtask
  task automatic pulse(input logic [3:0] i, input logic [7:0] e);
    iev <= i;
    eev <= e;
    cause <= ~i[1:0];
    @(posedge i_clk);
    iev <= 4'h0;
    eev <= 8'h00;
    @(posedge i_clk);
  endtask
  task automatic irq_is(input logic v);
    @(negedge i_clk);
    `CHK(irq, v)
    @(posedge i_clk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(cbi_pkg::IRQ_ENABLE_OFS, cbi_pkg::ENABLE_RESET);
    rchk(cbi_pkg::ERROR_IRQ_ENABLE_OFS, cbi_pkg::ENABLE_RESET);
    wr(cbi_pkg::IRQ_ENABLE_OFS, 32'hFFFF_FFFF, 4'hF, cbi_pkg::RESP_OKAY);
    wr(cbi_pkg::ERROR_IRQ_ENABLE_OFS, 32'hFFFF_FFFF, 4'hF, cbi_pkg::RESP_OKAY);
    rchk(cbi_pkg::IRQ_ENABLE_OFS, cbi_pkg::IRQ_EN_MASK);
    rchk(cbi_pkg::ERROR_IRQ_ENABLE_OFS, cbi_pkg::ERR_EN_MASK);
    wr(cbi_pkg::IRQ_ENABLE_OFS, 32'h0000_0000, 4'h4, cbi_pkg::RESP_OKAY);
    rchk(cbi_pkg::IRQ_ENABLE_OFS, 32'h0000_1111);
    rchk(12'h000, 32'h0000_0000, cbi_pkg::RESP_SLVERR);
    wr(12'h000, 32'hFFFF_FFFF, 4'hF, cbi_pkg::RESP_SLVERR);
    wr(cbi_pkg::IRQ_ENABLE_OFS, 32'h0000_0000, 4'hF, cbi_pkg::RESP_OKAY);
    wr(cbi_pkg::ERROR_IRQ_ENABLE_OFS, 32'h0000_0000, 4'hF, cbi_pkg::RESP_OKAY);
  endtask
  task automatic t_events;
    logic [31:0] ie [4] = '{32'h0000_0001, 32'h0000_0010, 32'h0000_0700, 32'h0000_1000};
    pulse(4'hF, 8'hFF);
    irq_is(1'b0);
    rchk(cbi_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
    wr(cbi_pkg::IRQ_ENABLE_OFS, cbi_pkg::IRQ_EN_MASK, 4'hF, cbi_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      pulse(4'(1 << i), 8'h00);
      irq_is(1'b1);
      rchk(cbi_pkg::IRQ_STATUS_OFS, ie[i]);
      rchk(cbi_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
      irq_is(1'b0);
    end
  endtask
  task automatic t_errors;
    logic [7:0] e;
    logic [11:0] es;
    logic [31:0] x;
    es = cbi_pkg::ERROR_IRQ_STATUS_OFS;
    wr(cbi_pkg::ERROR_IRQ_ENABLE_OFS, cbi_pkg::ERR_EN_MASK, 4'hF, cbi_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      e = 8'(1 << i);
      pulse(4'h0, e);
      irq_is(1'b1);
      rchk(cbi_pkg::IRQ_STATUS_OFS, 32'h4000_0000);
      x = {4'h0, e[7:4], 4'h0, e[3:0], 16'h0000};
      rchk(es, x);
      rchk(cbi_pkg::ERROR_IRQ_STATUS_OFS, 32'h0000_0000);
    end
    // every channel is read but only one shows a fault, so only that one may flag
    for (int n = 0; n < 4; n++)
    begin
      acond <= 4'(1 << n);
      ard <= 4'hF;
      @(posedge i_clk);
      ard <= 4'h0;
      acond <= 4'h0;
      @(posedge i_clk);
      rchk(cbi_pkg::ERROR_IRQ_STATUS_OFS, 32'(1 << n));
    end
  endtask
  task automatic t_settle;
    wr(cbi_pkg::IRQ_ENABLE_OFS, 32'h000F_0000, 4'hF, cbi_pkg::RESP_OKAY);
    for (int m = 0; m < 2; m++)
    begin
      mm <= 1'(m);
      settle <= 4'hF;
      @(posedge i_clk);
      // channels zero and two fall, so channel zero's own assertion is reached
      settle <= 4'hA;
      @(posedge i_clk);
      rchk(cbi_pkg::IRQ_STATUS_OFS, (m == 1) ? 32'h0005_0000 : 32'h0000_0000);
    end
    mm <= 1'b0;
    settle <= 4'h0;
    @(posedge i_clk);
  endtask
  task automatic t_disable;
    wr(cbi_pkg::ERROR_IRQ_ENABLE_OFS, 32'h0800_0000, 4'hF, cbi_pkg::RESP_OKAY);
    wr(cbi_pkg::IRQ_ENABLE_OFS, 32'h0000_1000, 4'hF, cbi_pkg::RESP_OKAY);
    pulse(4'h8, 8'h80);
    irq_is(1'b1);
    wr(cbi_pkg::ERROR_IRQ_ENABLE_OFS, 32'h0000_0000, 4'hF, cbi_pkg::RESP_OKAY);
    wr(cbi_pkg::IRQ_ENABLE_OFS, 32'h0000_0000, 4'hF, cbi_pkg::RESP_OKAY);
    irq_is(1'b0);
    rchk(cbi_pkg::ERROR_IRQ_STATUS_OFS, 32'h0000_0000);
    rchk(cbi_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #50000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, mm} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {settle, iev, ard, acond, cause, eev} = '0;
    i_nrst = 1'b0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_events();
    t_errors();
    t_settle();
    t_disable();
    close_out();
  end
endmodule
`default_nettype wire
